// ### mrm_pkg.sv
// Package: register map, field layouts and types of the magnetometer register block
package mrm_pkg;
   localparam logic [7:0] ADDR_IDENTITY   = 8'h40;
   localparam logic [7:0] ADDR_RESERVED   = 8'h41;
   localparam logic [7:0] ADDR_X_LOW      = 8'h42;
   localparam logic [7:0] ADDR_X_HIGH     = 8'h43;
   localparam logic [7:0] ADDR_Y_LOW      = 8'h44;
   localparam logic [7:0] ADDR_Y_HIGH     = 8'h45;
   localparam logic [7:0] ADDR_Z_LOW      = 8'h46;
   localparam logic [7:0] ADDR_Z_HIGH     = 8'h47;
   localparam logic [7:0] ADDR_HALL_LOW   = 8'h48;
   localparam logic [7:0] ADDR_HALL_HIGH  = 8'h49;
   localparam logic [7:0] ADDR_INT_FLAGS  = 8'h4a;
   localparam logic [7:0] ADDR_POWER      = 8'h4b;
   localparam logic [7:0] ADDR_OPMODE     = 8'h4c;
   localparam logic [7:0] ADDR_INT_EN     = 8'h4d;
   localparam logic [7:0] ADDR_PIN_CFG    = 8'h4e;
   localparam logic [7:0] ADDR_LOW_LIMIT  = 8'h4f;
   localparam logic [7:0] ADDR_HIGH_LIMIT = 8'h50;

   // Identity value is arbitrary
   localparam logic [7:0] IDENTITY_VALUE  = 8'ha5;

   localparam logic [7:0] RST_INT_FLAGS   = 8'h00;
   localparam logic [7:0] RST_POWER       = 8'h01;
   localparam logic [7:0] RST_OPMODE      = 8'h06;
   localparam logic [7:0] RST_INT_EN      = 8'h3f;
   localparam logic [7:0] RST_PIN_CFG     = 8'h07;
   localparam logic [7:0] RST_LIMIT       = 8'h00;
   localparam logic [7:0] ZERO_BYTE       = 8'h00;

   localparam int PWR_ENABLE_BIT   = 0;
   localparam int PWR_RESET_LO_BIT = 1;
   localparam int PWR_THREE_WIRE   = 2;
   localparam int PWR_RESET_HI_BIT = 7;
   localparam logic [7:0] PWR_WRITE_MASK = 8'h87;

   localparam int XY_WIDTH   = 13;
   localparam int Z_WIDTH    = 15;
   localparam int HALL_WIDTH = 14;

   typedef enum logic [1:0] {MRM_SUSPEND, MRM_SLEEP} mrm_power_e;

   typedef struct packed {
      logic signed [XY_WIDTH-1:0] x_field;
      logic signed [XY_WIDTH-1:0] y_field;
      logic signed [Z_WIDTH-1:0]  z_field;
      logic [HALL_WIDTH-1:0]      hall;
      logic                       x_selftest;
      logic                       y_selftest;
      logic                       z_selftest;
      logic                       ready;
   } mrm_sample_s;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mrm_access_s;
endpackage

// ### mrm_regs.sv
// Magnetometer register file: field results, identity, power control and config
`timescale 1ns/1ps
module mrm_regs
(
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire mrm_pkg::mrm_access_s acc,
   input  wire mrm_pkg::mrm_sample_s sample,
   input  wire logic                sample_load,
   output logic [7:0]               rdata,
   output logic                     power_sleep,
   output logic                     three_wire_select,
   output logic [7:0]               operation_rate_selftest,
   output logic [7:0]               interrupt_enables,
   output logic [7:0]               pin_and_axis_config,
   output logic [7:0]               low_limit,
   output logic [7:0]               high_limit
);
   import mrm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   mrm_sample_s held;
   mrm_power_e  pstate;
   logic [7:0]  power_and_soft_reset;
   logic [7:0]  interrupt_flags;
   // Trigger bits are write-only pulses, never stored
   localparam logic [7:0] TRIGGER_BITS = 8'(1 << PWR_RESET_HI_BIT) | 8'(1 << PWR_RESET_LO_BIT);

   wire         wr_power   = acc.wr && acc.addr == ADDR_POWER;
   wire [7:0]   pwr_wval   = acc.wdata & PWR_WRITE_MASK;
   // Soft reset is ignored in suspend
   wire         soft_reset = wr_power && pwr_wval[PWR_RESET_HI_BIT] && pwr_wval[PWR_RESET_LO_BIT]
                             && power_and_soft_reset[PWR_ENABLE_BIT] && pwr_wval[PWR_ENABLE_BIT];
   // Other registers are frozen in suspend; only power control accepts writes, reads still answer
   wire         awake      = power_and_soft_reset[PWR_ENABLE_BIT];
   wire         wr_cfg     = acc.wr && awake && !soft_reset;

   // Assembled byte images
   wire [7:0]   x_low  = {held.x_field[4:0], 2'b00, held.x_selftest};
   wire [7:0]   x_high = held.x_field[12:5];
   wire [7:0]   y_low  = {held.y_field[4:0], 2'b00, held.y_selftest};
   wire [7:0]   y_high = held.y_field[12:5];
   wire [7:0]   z_low  = {held.z_field[6:0], held.z_selftest};
   wire [7:0]   z_high = held.z_field[14:7];
   wire [7:0]   h_low  = {held.hall[5:0], 1'b0, held.ready};
   wire [7:0]   h_high = held.hall[13:6];
   // Identity gated by power enable
   wire [7:0]   id_val = awake ? IDENTITY_VALUE : ZERO_BYTE;

   logic [7:0] read_mux;
   always_comb
   begin
      unique case (acc.addr)
         ADDR_IDENTITY:   read_mux = id_val;
         ADDR_RESERVED:   read_mux = ZERO_BYTE;
         ADDR_X_LOW:      read_mux = x_low;
         ADDR_X_HIGH:     read_mux = x_high;
         ADDR_Y_LOW:      read_mux = y_low;
         ADDR_Y_HIGH:     read_mux = y_high;
         ADDR_Z_LOW:      read_mux = z_low;
         ADDR_Z_HIGH:     read_mux = z_high;
         ADDR_HALL_LOW:   read_mux = h_low;
         ADDR_HALL_HIGH:  read_mux = h_high;
         ADDR_INT_FLAGS:  read_mux = interrupt_flags;
         ADDR_POWER:      read_mux = power_and_soft_reset;
         ADDR_OPMODE:     read_mux = operation_rate_selftest;
         ADDR_INT_EN:     read_mux = interrupt_enables;
         ADDR_PIN_CFG:    read_mux = pin_and_axis_config;
         ADDR_LOW_LIMIT:  read_mux = low_limit;
         ADDR_HIGH_LIMIT: read_mux = high_limit;
         default:         read_mux = ZERO_BYTE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         rdata <= ZERO_BYTE;
      else if (acc.rd)
         rdata <= read_mux;
   end

   // Trigger bits never store, so they always read back zero
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         power_and_soft_reset <= RST_POWER;
      else if (wr_power)
         power_and_soft_reset <= pwr_wval & ~TRIGGER_BITS;
   end

   // Power state follows the enable bit; soft reset lands in sleep
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         pstate <= MRM_SLEEP;
      else if (wr_power)
         pstate <= pwr_wval[PWR_ENABLE_BIT] ? MRM_SLEEP : MRM_SUSPEND;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         power_sleep <= 1'b1;
      else if (wr_power)
         power_sleep <= pwr_wval[PWR_ENABLE_BIT];
   end

   assign three_wire_select = power_and_soft_reset[PWR_THREE_WIRE];

   // Soft reset reloads reset values into all but power control and read data
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         operation_rate_selftest <= RST_OPMODE;
         interrupt_enables       <= RST_INT_EN;
         pin_and_axis_config     <= RST_PIN_CFG;
         low_limit               <= RST_LIMIT;
         high_limit              <= RST_LIMIT;
      end
      else if (soft_reset)
      begin
         operation_rate_selftest <= RST_OPMODE;
         interrupt_enables       <= RST_INT_EN;
         pin_and_axis_config     <= RST_PIN_CFG;
         low_limit               <= RST_LIMIT;
         high_limit              <= RST_LIMIT;
      end
      else if (wr_cfg)
      begin
         if (acc.addr == ADDR_OPMODE)     operation_rate_selftest <= acc.wdata;
         if (acc.addr == ADDR_INT_EN)     interrupt_enables       <= acc.wdata;
         if (acc.addr == ADDR_PIN_CFG)    pin_and_axis_config     <= acc.wdata;
         if (acc.addr == ADDR_LOW_LIMIT)  low_limit               <= acc.wdata;
         if (acc.addr == ADDR_HIGH_LIMIT) high_limit              <= acc.wdata;
      end
   end

   // Interrupt sources live outside this block; flags only reset here
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         interrupt_flags <= RST_INT_FLAGS;
      else if (soft_reset)
         interrupt_flags <= RST_INT_FLAGS;
   end

   // Results keep their signed form; self-test flags default one
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         held <= '{x_selftest: 1'b1, y_selftest: 1'b1, z_selftest: 1'b1, default: '0};
      else if (soft_reset)
         held <= '{x_selftest: 1'b1, y_selftest: 1'b1, z_selftest: 1'b1, default: '0};
      else if (sample_load && awake)
         held <= sample;
   end

   ////////////////////////////////////////////////////////////////////////////
   property p_id_gate;
      @(posedge core_clk) disable iff (rst)
      (acc.rd && acc.addr == ADDR_IDENTITY) |=> (rdata == ($past(awake) ? IDENTITY_VALUE : ZERO_BYTE));
   endproperty
   a_id_gate: assert property (p_id_gate) else $error("identity gating wrong");

   property p_reserved;
      @(posedge core_clk) disable iff (rst)
      (acc.rd && acc.addr == ADDR_RESERVED) |=> rdata == ZERO_BYTE;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved not zero");

   property p_x_low;
      @(posedge core_clk) disable iff (rst)
      (acc.rd && acc.addr == ADDR_X_LOW) |=> rdata[2:1] == 2'b00 && rdata[7:3] == $past(held.x_field[4:0]);
   endproperty
   a_x_low: assert property (p_x_low) else $error("x low layout wrong");

   property p_y_high;
      @(posedge core_clk) disable iff (rst)
      (acc.rd && acc.addr == ADDR_Y_HIGH) |=> rdata == $past(held.y_field[12:5]);
   endproperty
   a_y_high: assert property (p_y_high) else $error("y high layout wrong");

   property p_z_low;
      @(posedge core_clk) disable iff (rst)
      (acc.rd && acc.addr == ADDR_Z_LOW) |=> rdata[7:1] == $past(held.z_field[6:0]);
   endproperty
   a_z_low: assert property (p_z_low) else $error("z low layout wrong");

   property p_hall;
      @(posedge core_clk) disable iff (rst)
      (acc.rd && acc.addr == ADDR_HALL_LOW) |=> rdata[1] == 1'b0 && rdata[0] == $past(held.ready);
   endproperty
   a_hall: assert property (p_hall) else $error("hall low layout wrong");

   sequence s_soft_reset;
      soft_reset;
   endsequence
   property p_soft_reset;
      @(posedge core_clk) disable iff (rst)
      s_soft_reset |=> power_and_soft_reset[PWR_RESET_HI_BIT] == 1'b0 && power_sleep
                       && interrupt_enables == RST_INT_EN && held.x_selftest;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset effect wrong");

   property p_power;
      @(posedge core_clk) disable iff (rst)
      wr_power |=> power_sleep == $past(pwr_wval[PWR_ENABLE_BIT]) && (pstate == MRM_SLEEP) == power_sleep;
   endproperty
   a_power: assert property (p_power) else $error("power state wrong");

   property p_selftest_rst;
      @(posedge core_clk) $fell(rst) |-> held.x_selftest && held.y_selftest && held.z_selftest;
   endproperty
   a_selftest_rst: assert property (p_selftest_rst) else $error("selftest default wrong");
endmodule

// ### mrm_host.sv
// Host controller model: one-cycle register read and write strobes
`timescale 1ns/1ps
module mrm_host
(
   input  wire logic            core_clk,
   output mrm_pkg::mrm_access_s acc
);
   import mrm_pkg::*;
   initial acc = '0;
   // Launch after a falling edge, hold across one rising edge, then release
   // Released address and data are inverted so stale values never match by luck
   task automatic xfer(input logic [1:0] kind, input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      acc = '{wr: kind[1], rd: kind[0], addr: a, wdata: d};
      @(negedge core_clk);
      acc = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule

// ### tb.sv
// Testbench: register reads, field packing, power modes and soft reset
`timescale 1ns/1ps
module tb;
   import mrm_pkg::*;
   localparam logic [7:0] RST_TAB [8] = '{RST_INT_FLAGS, RST_POWER, RST_OPMODE, RST_INT_EN, RST_PIN_CFG,
                                          RST_LIMIT, RST_LIMIT, ZERO_BYTE};
   logic        core_clk;
   logic        rst;
   mrm_access_s acc;
   mrm_sample_s sample;
   mrm_sample_s held;
   logic        sample_load;
   logic [7:0]  rdata;
   logic        power_sleep;
   logic        three_wire_select;
   logic [7:0]  cfg [5];
   logic [7:0]  last [5];
   logic [7:0]  exp_q [$];
   logic        rd_q;
   logic [31:0] seed;
   logic [95:0] rnd;
   int          fail_count;
   int          checked;
   mrm_host host (.core_clk(core_clk), .acc(acc));
   mrm_regs dut (.core_clk(core_clk), .rst(rst), .acc(acc), .sample(sample), .sample_load(sample_load),
      .rdata(rdata), .power_sleep(power_sleep), .three_wire_select(three_wire_select),
      .operation_rate_selftest(cfg[0]), .interrupt_enables(cfg[1]), .pin_and_axis_config(cfg[2]),
      .low_limit(cfg[3]), .high_limit(cfg[4]));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nx();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic cmp(input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.xfer(2'b01, a, 8'h00);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.xfer(2'b10, a, d);
   endtask
   task automatic load();
      @(negedge core_clk);
      rnd = {nx(), nx(), nx()};
      sample = rnd[$bits(mrm_sample_s)-1:0];
      sample_load = 1'b1;
      @(negedge core_clk);
      sample_load = 1'b0;
   endtask
   task automatic close_out();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Read data registers on the read edge itself, so compare on the next falling edge
   always @(posedge core_clk) rd_q <= acc.rd;
   always @(negedge core_clk)
      if (rd_q === 1'b1)
         cmp(exp_q.pop_front(), rdata);
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial
   begin
      #100000;
      fail_count++;
      close_out();
   end
   initial
   begin
      rst = 1'b1;
      sample = '0;
      sample_load = 1'b0;
      seed = 32'h2f144467;
      rd_q = 1'b0;
      fail_count = 0;
      checked = 0;
      repeat (16) @(posedge core_clk);
      @(negedge core_clk) rst = 1'b0;
      rd(ADDR_IDENTITY, IDENTITY_VALUE);
      rd(ADDR_RESERVED, ZERO_BYTE);
      for (int a = 0; a < 3; a++) rd(ADDR_X_LOW + 8'(2 * a), 8'h01);
      for (int i = 0; i < 8; i++) rd(ADDR_INT_FLAGS + 8'(i), RST_TAB[i]);
      cmp(8'h01, {7'h00, power_sleep});
      $display("test reset_values done");
      for (int n = 0; n < 4; n++)
      begin
         load();
         rd(ADDR_X_LOW, {sample.x_field[4:0], 2'b00, sample.x_selftest});
         rd(ADDR_X_HIGH, sample.x_field[12:5]);
         rd(ADDR_Y_LOW, {sample.y_field[4:0], 2'b00, sample.y_selftest});
         rd(ADDR_Y_HIGH, sample.y_field[12:5]);
         rd(ADDR_Z_LOW, {sample.z_field[6:0], sample.z_selftest});
         rd(ADDR_Z_HIGH, sample.z_field[14:7]);
         rd(ADDR_HALL_LOW, {sample.hall[5:0], 1'b0, sample.ready});
         rd(ADDR_HALL_HIGH, sample.hall[13:6]);
      end
      $display("test field_packing done");
      for (int i = 0; i < 5; i++)
      begin
         last[i] = 8'(nx());
         wr(ADDR_OPMODE + 8'(i), last[i]);
         cmp(last[i], cfg[i]);
         rd(ADDR_OPMODE + 8'(i), last[i]);
      end
      wr(ADDR_IDENTITY, 8'h00);
      rd(ADDR_IDENTITY, IDENTITY_VALUE);
      wr(ADDR_POWER, 8'h7d);
      rd(ADDR_POWER, 8'h05);
      cmp(8'h01, {7'h00, three_wire_select});
      $display("test register_access done");
      held = sample;
      wr(ADDR_POWER, 8'h00);
      cmp(8'h00, {7'h00, power_sleep});
      rd(ADDR_IDENTITY, ZERO_BYTE);
      wr(ADDR_OPMODE, ~last[0]);
      load();
      wr(ADDR_POWER, 8'h82);
      cmp(8'h00, {7'h00, power_sleep});
      wr(ADDR_POWER, 8'h01);
      cmp(8'h01, {7'h00, power_sleep});
      rd(ADDR_IDENTITY, IDENTITY_VALUE);
      rd(ADDR_OPMODE, last[0]);
      rd(ADDR_X_HIGH, held.x_field[12:5]);
      $display("test suspend done");
      wr(ADDR_POWER, 8'h83);
      cmp(8'h01, {7'h00, power_sleep});
      for (int i = 1; i < 8; i++) rd(ADDR_INT_FLAGS + 8'(i), RST_TAB[i]);
      rd(ADDR_X_LOW, 8'h01);
      rd(ADDR_HALL_LOW, ZERO_BYTE);
      $display("test soft_reset done");
      repeat (2) @(negedge core_clk);
      close_out();
   end
endmodule
